// ==== src/analog_input_zone_alarm.sv ====
`timescale 1ns/1ps
module analog_input_zone_alarm #(
  parameter int TICK_CYCLES = aizone_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // channel inputs
  input wire logic [15:0] word_i,
  input wire aizone_pkg::tod_t tod_i,
  input wire logic [31:0] pulse_cnt_i,
  // results
  output logic signed [aizone_pkg::ENG_W-1:0] eng_o,
  output logic [2:0] zone_o,
  output logic [1:0] dp_o,
  output aizone_pkg::zone_act_t act_o,
  output logic [aizone_pkg::N_DO-1:0] do_o
);
  import aizone_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic signed [ENG_W-1:0] cfg48(input logic [31:0] lo, input logic [31:0] hi);
    cfg48 = {hi[ENG_W-33:0], lo};
  endfunction : cfg48

  function automatic logic [6:0] avg_len(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > 3'd4) ? 3'd4 : sel;
    avg_len = 7'(AVG_MIN) << s;
  endfunction : avg_len

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [31:0] cfg_r [0:CFG_WORDS-1];
  logic [5:0] widx;
  assign widx = addr_i[7:2];

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
        cfg_r[i] <= CFG_RST;
    end
    else if (ce_i && wr_i && (int'(widx) < CFG_WORDS))
      cfg_r[widx] <= wdata_i;
  end

  logic [31:0] ctrl;
  logic fmt_int;
  filter_t filt;
  source_t src;
  logic [6:0] n_avg;
  logic [2:0] n_zones;
  logic ext;
  logic [6:0] tconst;
  assign ctrl = cfg_r[OFS_CTRL[7:2]];
  assign fmt_int = ctrl[CTRL_FMT_BIT];
  assign filt = (ctrl[CTRL_FILT_LSB +: 2] == 2'd3) ? FILT_NONE : filter_t'(ctrl[CTRL_FILT_LSB +: 2]);
  assign src = (ctrl[CTRL_SRC_LSB +: 2] == 2'd3) ? SRC_IO : source_t'(ctrl[CTRL_SRC_LSB +: 2]);
  assign n_avg = avg_len(ctrl[CTRL_AVG_LSB +: 3]);
  assign n_zones = (ctrl[CTRL_ZN_LSB +: 3] > 3'd5) ? 3'd5 : ctrl[CTRL_ZN_LSB +: 3];
  assign ext = ctrl[CTRL_EXT_BIT];
  assign tconst = (cfg_r[OFS_TCONST[7:2]][6:0] > TC_MAX) ? TC_MAX : cfg_r[OFS_TCONST[7:2]][6:0];

  // ----------------------------------------
  // one-second tick and pipeline
  // ----------------------------------------
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else if (ce_i)
    begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 32'd1;
      s2_r <= tick_r;
      s3_r <= s2_r;
    end
  end

  // ----------------------------------------
  // input decode
  // ----------------------------------------
  logic signed [31:0] raw;
  always_comb
  begin
    raw = 32'(signed'(word_i));
    if (!fmt_int)
    begin
      if (raw < PCT_MIN) raw = PCT_MIN;
      if (raw > PCT_MAX) raw = PCT_MAX;
    end
  end

  // ----------------------------------------
  // moving average
  // ----------------------------------------
  logic signed [15:0] hist_r [0:HIST-1];
  logic [5:0] wp_r;
  logic [6:0] cnt_r;
  logic signed [23:0] sum_r;
  logic do_filt;
  logic full;
  logic signed [23:0] sum_nxt;
  logic [6:0] cnt_nxt;
  assign do_filt = tick_r && (src == SRC_IO);
  assign full = (cnt_r >= n_avg);
  assign cnt_nxt = full ? n_avg : cnt_r + 7'd1;
  assign sum_nxt = sum_r + 24'(raw) - (full ? 24'(hist_r[wp_r - n_avg[5:0]]) : 24'sd0);

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wp_r <= '0;
      cnt_r <= '0;
      sum_r <= '0;
    end
    else if (ce_i && wr_i && widx == OFS_CTRL[7:2])
    begin
      cnt_r <= '0;
      sum_r <= '0;
    end
    else if (ce_i && do_filt && filt == FILT_AVG)
    begin
      wp_r <= wp_r + 6'd1;
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (ce_i && do_filt && filt == FILT_AVG)
      hist_r[wp_r] <= raw[15:0];
  end

  // ----------------------------------------
  // first-order lag
  // ----------------------------------------
  logic signed [31:0] lag_r;
  logic signed [31:0] lag_step;
  assign lag_step = ((raw <<< FRAC) - lag_r) / 32'(signed'({1'b0, tconst} + 8'd1));
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      lag_r <= '0;
    else if (ce_i && do_filt && filt == FILT_DELAY)
      lag_r <= lag_r + lag_step;
  end

  // ----------------------------------------
  // stage 1: channel value
  // ----------------------------------------
  logic signed [31:0] val_r;
  logic signed [63:0] pden;
  logic signed [63:0] pscaled;
  always_comb
  begin
    pden = 64'(signed'(cfg_r[OFS_PULSE100[7:2]])) - 64'(signed'(cfg_r[OFS_PULSE0[7:2]]));
    pscaled = 64'sd0;
    if (pden != 64'sd0)
      pscaled = ((signed'(64'({1'b0, pulse_cnt_i})) - 64'(signed'(cfg_r[OFS_PULSE0[7:2]])))
                 * 64'(PCT_FULL)) / pden;
    if (pscaled < 64'sd0) pscaled = 64'sd0;
    if (pscaled > 64'(PCT_FULL)) pscaled = 64'(PCT_FULL);
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      val_r <= '0;
    else if (ce_i && tick_r)
    begin
      unique case (src)
        SRC_TIME: val_r <= 32'(tod_i.hour) * 32'sd10000 + 32'(tod_i.minute) * 32'sd100
                           + 32'(tod_i.second);
        SRC_PULSE: val_r <= pscaled[31:0];
        SRC_IO:
          unique case (filt)
            FILT_AVG: val_r <= 32'(sum_nxt / 24'(signed'({1'b0, cnt_nxt})));
            FILT_DELAY: val_r <= (lag_r + lag_step) >>> FRAC;
            FILT_NONE: val_r <= raw;
          endcase
      endcase
    end
  end

  // ----------------------------------------
  // stage 2: engineering value in milli-units
  // ----------------------------------------
  logic signed [ENG_W-1:0] eng0;
  logic signed [ENG_W-1:0] eng100;
  logic signed [ENG_W-1:0] factor;
  logic signed [79:0] pct_term;
  logic signed [79:0] int_term;
  assign eng0 = cfg48(cfg_r[OFS_ENG0[7:2]], cfg_r[OFS_ENG0[7:2] + 6'd1]);
  assign eng100 = cfg48(cfg_r[OFS_ENG100[7:2]], cfg_r[OFS_ENG100[7:2] + 6'd1]);
  assign factor = cfg48(cfg_r[OFS_FACTOR[7:2]], cfg_r[OFS_FACTOR[7:2] + 6'd1]);
  assign pct_term = (80'(eng100) - 80'(eng0)) * 80'(val_r) / 80'(PCT_FULL);
  assign int_term = 80'(val_r) * 80'(factor);

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      eng_o <= '0;
    else if (ce_i && s2_r)
    begin
      if (src == SRC_TIME)
        eng_o <= ENG_W'(val_r * MILLI);
      else if (src == SRC_IO && !fmt_int)
        eng_o <= eng0 + pct_term[ENG_W-1:0];
      else
        eng_o <= int_term[ENG_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dp_o <= '0;
    else if (ce_i)
      dp_o <= (src == SRC_TIME) ? 2'd0 : ctrl[CTRL_DP_LSB +: 2];
  end

  // ----------------------------------------
  // stage 3: zones and entry actions
  // ----------------------------------------
  logic [2:0] zone_nxt;
  always_comb
  begin
    zone_nxt = 3'd0;
    for (int z = N_ZONES - 1; z >= 0; z--)
    begin
      if (3'(z) < n_zones
          && eng_o >= cfg48(cfg_r[OFS_ZONE[7:2] + 6'(4 * z)], cfg_r[OFS_ZONE[7:2] + 6'(4 * z + 1)])
          && eng_o <= cfg48(cfg_r[OFS_ZONE[7:2] + 6'(4 * z + 2)], cfg_r[OFS_ZONE[7:2] + 6'(4 * z + 3)]))
        zone_nxt = 3'(z + 1);
    end
  end

  logic [31:0] zact;
  assign zact = (zone_nxt == 3'd0) ? 32'h0000_0000 : cfg_r[OFS_ZACT[7:2] + 6'(zone_nxt) - 6'd1];

  logic [N_DO-1:0] alarm_do_r;
  logic [15:0] evcnt_r;
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zone_o <= '0;
      act_o <= '0;
      alarm_do_r <= '0;
      evcnt_r <= '0;
    end
    else if (ce_i)
    begin
      act_o <= '0;
      if (s3_r)
      begin
        zone_o <= zone_nxt;
        alarm_do_r <= ext ? zact[ZACT_DO_LSB +: N_DO] : '0;
        if (zone_nxt != 3'd0 && zone_nxt != zone_o)
        begin
          act_o.event_pulse <= zact[ZACT_LOG_BIT];
          act_o.pi_reset <= zact[ZACT_PI_LSB +: N_PI];
          if (zact[ZACT_LOG_BIT])
            evcnt_r <= evcnt_r + 16'd1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      do_o <= '0;
    else if (ce_i)
      do_o <= alarm_do_r | cfg_r[OFS_DO_CMD[7:2]][N_DO-1:0];
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (ce_i)
    begin
      if (!rd_i)
        rdata_o <= '0;
      else if (int'(widx) < CFG_WORDS)
        rdata_o <= cfg_r[widx];
      else if (addr_i == OFS_STATUS)
        rdata_o <= {22'd0, cnt_r, zone_o};
      else if (addr_i == OFS_ENG_L)
        rdata_o <= eng_o[31:0];
      else if (addr_i == OFS_ENG_H)
        rdata_o <= 32'(eng_o[ENG_W-1:32]);
      else if (addr_i == OFS_EVCNT)
        rdata_o <= {16'd0, evcnt_r};
      else
        rdata_o <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_pct_range;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && tick_r && src == SRC_IO && filt == FILT_NONE && !fmt_int)
      |=> (val_r >= PCT_MIN && val_r <= PCT_MAX);
  endproperty
  a_pct_range: assert property (p_pct_range) else $error("percent value out of range");

  property p_filter_bypass;
    @(posedge clock_i) disable iff (!rstn_i)
      (src != SRC_IO && !wr_i) |=> $stable(sum_r) && $stable(lag_r);
  endproperty
  a_filter_bypass: assert property (p_filter_bypass) else $error("filter moved while bypassed");

  property p_filter_tick;
    @(posedge clock_i) disable iff (!rstn_i)
      (!tick_r && !wr_i) |=> $stable(cnt_r) && $stable(lag_r);
  endproperty
  a_filter_tick: assert property (p_filter_tick) else $error("filter moved without tick");

  property p_time_dp;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && src == SRC_TIME) |=> dp_o == 2'd0;
  endproperty
  a_time_dp: assert property (p_time_dp) else $error("decimal places not zero for time");

  property p_zone_max;
    @(posedge clock_i) disable iff (!rstn_i)
      zone_o <= 3'd5;
  endproperty
  a_zone_max: assert property (p_zone_max) else $error("zone index beyond five");

  property p_entry_once;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && act_o.event_pulse) |-> zone_o != 3'd0 && zone_o != $past(zone_o);
  endproperty
  a_entry_once: assert property (p_entry_once) else $error("event without zone entry");

  property p_pi_pulse;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && act_o.pi_reset != '0) |=> act_o.pi_reset == '0;
  endproperty
  a_pi_pulse: assert property (p_pi_pulse) else $error("pulse reset held too long");

  property p_basic_variant;
    @(posedge clock_i) disable iff (!rstn_i)
      (ce_i && s3_r && !ext) |=> alarm_do_r == '0;
  endproperty
  a_basic_variant: assert property (p_basic_variant) else $error("zone drive on basic unit");

  property p_do_or;
    @(posedge clock_i) disable iff (!rstn_i)
      ce_i |=> do_o == ($past(alarm_do_r) | $past(cfg_r[OFS_DO_CMD[7:2]][N_DO-1:0]));
  endproperty
  a_do_or: assert property (p_do_or) else $error("output not OR of drives");
endmodule : analog_input_zone_alarm

// ==== common/aizone_pkg.sv ====
// How it works
// - percent format: value x100, -2000 to 12000
// - integer format: signed 16-bit word
// - filter none/average/delay; bypassed for time, pulse
// - moving average over 4/8/16/32/64 samples
// - filters advance only on one-second tick
// - delay filter lag constant 0 to 100 s
// - percent maps linearly between 0%/100% values
// - integer value times configured factor
// - decimal places 0-3, zero for time
// - zone count none, 1, 2, 3, 4, 5
// - gaps between zones belong to none
// - logged zones raise event on entry
// - zone entry clears selected pulse counters
// - zone entry switches chosen discrete outputs
// - zone output drive only on extended variant
// - zone drive holds while value stays inside
// - output is zone drive OR host command
// - pulse count scaled to 0..10000
// - time of day usable as channel input
package aizone_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TCONST = 8'h04;
  localparam logic [7:0] OFS_ENG0 = 8'h08;
  localparam logic [7:0] OFS_ENG100 = 8'h10;
  localparam logic [7:0] OFS_FACTOR = 8'h18;
  localparam logic [7:0] OFS_PULSE0 = 8'h20;
  localparam logic [7:0] OFS_PULSE100 = 8'h24;
  localparam logic [7:0] OFS_ZONE = 8'h28;
  localparam logic [7:0] OFS_ZACT = 8'h78;
  localparam logic [7:0] OFS_DO_CMD = 8'h8C;
  localparam logic [7:0] OFS_STATUS = 8'h90;
  localparam logic [7:0] OFS_ENG_L = 8'h94;
  localparam logic [7:0] OFS_ENG_H = 8'h98;
  localparam logic [7:0] OFS_EVCNT = 8'h9C;
  localparam int CFG_WORDS = 36;
  // field positions
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_FILT_LSB = 1;
  localparam int CTRL_AVG_LSB = 3;
  localparam int CTRL_DP_LSB = 6;
  localparam int CTRL_SRC_LSB = 8;
  localparam int CTRL_ZN_LSB = 10;
  localparam int CTRL_EXT_BIT = 13;
  localparam int ZACT_LOG_BIT = 0;
  localparam int ZACT_PI_LSB = 8;
  localparam int ZACT_DO_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // sizes and limits
  localparam int N_ZONES = 5;
  localparam int N_PI = 8;
  localparam int N_DO = 8;
  localparam int HIST = 64;
  localparam int AVG_MIN = 4;
  localparam int ENG_W = 48;
  localparam logic signed [31:0] PCT_MIN = -32'sd2000;
  localparam logic signed [31:0] PCT_MAX = 32'sd12000;
  localparam logic signed [31:0] PCT_FULL = 32'sd10000;
  localparam logic signed [31:0] MILLI = 32'sd1000;
  localparam logic [6:0] TC_MAX = 7'd100;
  localparam logic [1:0] DP_MAX = 2'd3;
  localparam int FRAC = 8;

  typedef enum logic [1:0] {FILT_NONE, FILT_AVG, FILT_DELAY} filter_t;
  typedef enum logic [1:0] {SRC_IO, SRC_TIME, SRC_PULSE} source_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tod_t;

  typedef struct packed {
    logic event_pulse;
    logic [N_PI-1:0] pi_reset;
  } zone_act_t;
endpackage : aizone_pkg

// ==== testbench/sample_source.sv ====
`timescale 1ns/1ps
module sample_source (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // values the slave will report
  input wire logic [15:0] set_word_i,
  input wire aizone_pkg::tod_t set_tod_i,
  input wire logic [31:0] set_pulse_i,
  // lines toward the block
  output logic [15:0] word_o,
  output aizone_pkg::tod_t tod_o,
  output logic [31:0] pulse_o
);
  import aizone_pkg::*;
  // slave refreshes its registers one cycle late
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      word_o <= 16'h0000;
      tod_o <= '0;
      pulse_o <= 32'h0000_0000;
    end
    else
    begin
      word_o <= set_word_i;
      tod_o <= set_tod_i;
      pulse_o <= set_pulse_i;
    end
  end
endmodule : sample_source

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import aizone_pkg::*;
  localparam int TK = 8;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] w_set = 16'h0000;
  tod_t t_set = '0;
  logic [31:0] p_set = 32'h0000_0000;
  logic [15:0] word;
  tod_t tod;
  logic [31:0] pcnt;
  logic signed [ENG_W-1:0] eng;
  logic [2:0] zone;
  logic [1:0] dp;
  zone_act_t act;
  logic [N_DO-1:0] dout;
  logic [N_PI-1:0] pi_last = 8'h00;
  logic [31:0] r;
  int num_errors = 0;
  int n_checks = 0;
  int n_ev = 0;
  int cyc = 0;

  always #20 clock_i = ~clock_i;

  sample_source u_src (.clock_i(clock_i), .rstn_i(rstn_i), .set_word_i(w_set),
    .set_tod_i(t_set), .set_pulse_i(p_set), .word_o(word), .tod_o(tod), .pulse_o(pcnt));

  analog_input_zone_alarm #(.TICK_CYCLES(TK)) u_dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .word_i(word), .tod_i(tod), .pulse_cnt_i(pcnt), .eng_o(eng), .zone_o(zone),
    .dp_o(dp), .act_o(act), .do_o(dout));

  // ----------------------------------------
  // entry pulses and timeout
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    cyc++;
    if (act.event_pulse === 1'b1)
      n_ev++;
    if (act.pi_reset != 8'h00)
      pi_last <= act.pi_reset;
    if (cyc == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask : wreg

  task automatic w48(input logic [7:0] a, input logic [47:0] v);
    wreg(a, v[31:0]);
    wreg(a + 8'h04, {16'h0000, v[47:32]});
  endtask : w48

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg

  // new input word, then three ticks to flush the pipeline
  task automatic settle(input logic [15:0] w);
    @(posedge clock_i);
    w_set <= w;
    repeat (3 * TK) @(posedge clock_i);
    #1;
  endtask : settle

  // first two filter outputs after a step of the input
  task automatic step(input logic [15:0] w, input logic [47:0] e1, input logic [47:0] e2);
    logic [47:0] prev;
    prev = eng;
    @(posedge clock_i);
    w_set <= w;
    for (int i = 0; i < 4 * TK && eng === prev; i++)
    begin
      @(posedge clock_i);
      #1;
    end
    chk(eng, e1);
    repeat (TK) @(posedge clock_i);
    #1;
    chk(eng, e2);
  endtask : step

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    rreg(OFS_CTRL, r);
    chk(r, CFG_RST);
    rreg(8'hFC, r);
    chk(r, 48'h0000_0000_0000);
    wreg(OFS_TCONST, 32'h0000_00C8);
    rreg(OFS_TCONST, r);
    chk(r, 48'h0000_0000_00C8);
    wreg(OFS_STATUS, 32'hFFFF_FFFF);
    rreg(OFS_STATUS, r);
    chk(r[2:0], 48'h0000_0000_0000);
    // delay filter, lag of one second
    w48(OFS_ENG100, 48'h0000_0001_86A0);
    wreg(OFS_TCONST, 32'h0000_0001);
    wreg(OFS_CTRL, 32'h0000_0004);
    step(16'h2710, 48'h0000_0000_C350, 48'h0000_0001_24F8);
    // moving average of four
    wreg(OFS_CTRL, 32'h0000_0002);
    repeat (2 * TK) @(posedge clock_i);
    #1;
    chk(eng, 48'h0000_0001_86A0);
    repeat (4 * TK) @(posedge clock_i);
    step(16'h0000, 48'h0000_0001_24F8, 48'h0000_0000_C350);
    // percent clamp and decimals
    wreg(OFS_CTRL, 32'h0000_0080);
    settle(16'h4E20);
    chk(eng, 48'h0000_0001_D4C0);
    chk(dp, 48'h0000_0000_0002);
    settle(16'hF448);
    chk(eng, 48'hFFFF_FFFF_B1E0);
    // integer format
    w48(OFS_FACTOR, 48'h0000_0000_07D0);
    wreg(OFS_CTRL, 32'h0000_0001);
    settle(16'h8000);
    chk(eng, 48'hFFFF_FC18_0000);
    settle(16'h7FFF);
    chk(eng, 48'h0000_03E7_F830);
    // time of day with a slow delay filter selected
    wreg(OFS_TCONST, 32'h0000_0064);
    wreg(OFS_CTRL, 32'h0000_01C4);
    t_set <= '{hour: 5'h0C, minute: 6'h22, second: 6'h38};
    settle(16'h0000);
    chk(eng, 48'h0000_075B_CA00);
    chk(dp, 48'h0000_0000_0000);
    // pulse count with averaging selected
    w48(OFS_FACTOR, 48'h0000_0000_03E8);
    wreg(OFS_PULSE100, 32'h0000_03E8);
    wreg(OFS_CTRL, 32'h0000_0202);
    p_set <= 32'h0000_01F4;
    settle(16'h0000);
    chk(eng, 48'h0000_004C_4B40);
    p_set <= 32'h0000_07D0;
    settle(16'h0000);
    chk(eng, 48'h0000_0098_9680);
    // two zones, extended variant
    settle(16'hC000);
    wreg(OFS_CTRL, 32'h0000_2800);
    w48(OFS_ZONE, 48'h0000_0000_0000);
    w48(OFS_ZONE + 8'h08, 48'h0000_0000_C350);
    w48(OFS_ZONE + 8'h10, 48'h0000_0000_C350);
    w48(OFS_ZONE + 8'h18, 48'h0000_0001_86A0);
    wreg(OFS_ZACT, 32'h0005_0301);
    wreg(OFS_ZACT + 8'h04, 32'h000A_0C00);
    wreg(OFS_DO_CMD, 32'h0000_0080);
    settle(16'h07D0);
    chk(zone, 48'h0000_0000_0001);
    chk(dout, 48'h0000_0000_0085);
    chk(pi_last, 48'h0000_0000_0003);
    chk(n_ev, 48'h0000_0000_0001);
    settle(16'h1388);
    chk(zone, 48'h0000_0000_0001);
    chk(dout, 48'h0000_0000_0085);
    chk(n_ev, 48'h0000_0000_0001);
    settle(16'h1B58);
    chk(zone, 48'h0000_0000_0002);
    chk(dout, 48'h0000_0000_008A);
    chk(pi_last, 48'h0000_0000_000C);
    chk(n_ev, 48'h0000_0000_0001);
    w48(OFS_ZONE + 8'h10, 48'h0000_0000_EA60);
    settle(16'h157C);
    chk(zone, 48'h0000_0000_0000);
    chk(dout, 48'h0000_0000_0080);
    // basic variant keeps outputs to host command
    wreg(OFS_CTRL, 32'h0000_0800);
    settle(16'h07D0);
    chk(zone, 48'h0000_0000_0001);
    chk(dout, 48'h0000_0000_0080);
    chk(n_ev, 48'h0000_0000_0002);
    rreg(OFS_EVCNT, r);
    chk(r, 48'h0000_0000_0002);
    rreg(OFS_STATUS, r);
    chk(r[2:0], 48'h0000_0000_0001);
    give_verdict();
  end
endmodule : tb_top
